/* core/pcd_pkg.sv */
// Shared constants for the clock divider, phase selector and PLL control model.
// Assumes a single 40 MHz system clock and word-aligned Avalon-MM byte addresses.
package pcd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          PCD_ADDR_W      = 8;
	localparam logic [7:0]  PCD_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  PCD_OFF_STATUS  = 8'h04;
	localparam logic [7:0]  PCD_OFF_INT_ST  = 8'h08;
	localparam logic [7:0]  PCD_OFF_INT_EN  = 8'h0C;
	localparam logic [7:0]  PCD_OFF_INT_CLR = 8'h10;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          PCD_CTRL_THR_LSB = 0;
	localparam int          PCD_CTRL_TOL_LSB = 8;
	localparam int          PCD_CTRL_TAP8    = 16;
	localparam logic [7:0]  PCD_THR_RST      = 8'h08;
	localparam logic [7:0]  PCD_TOL_RST      = 8'h02;
	localparam int          PCD_INT_W        = 2;
	localparam int          PCD_INT_LOCKED   = 0;
	localparam int          PCD_INT_UNLOCKED = 1;

	// ----------------------------------------------------------------
	// Divider chain and phase selector
	// ----------------------------------------------------------------
	localparam int          PCD_STAGES       = 4;
	localparam int          PCD_DIV8_BIT     = 2;
	localparam int          PCD_DIV16_BIT    = 3;

	// ----------------------------------------------------------------
	// Oscillator model: half periods in system clock cycles
	// ----------------------------------------------------------------
	localparam int          PCD_PERIOD_W     = 8;
	localparam logic [7:0]  PCD_HI_MIN       = 8'h02;
	localparam logic [7:0]  PCD_HI_MAX       = 8'h0F;
	localparam logic [7:0]  PCD_LO_MIN       = 8'h10;
	localparam logic [7:0]  PCD_LO_MAX       = 8'h1F;
	localparam logic [7:0]  PCD_PERIOD_RST   = 8'h08;
	localparam logic [7:0]  PCD_LAG_MAX      = 8'hFF;

	// Phase-frequency detector states.
	typedef enum logic [2:0] {
		PCD_PFD_IDLE     = 3'b001,
		PCD_PFD_REF_LEAD = 3'b010,
		PCD_PFD_DIV_LEAD = 3'b100
	} pcd_pfd_t;

endpackage

/* core/pcd_top.sv */
// Digital side of a clock multiplier: divide-by-16 chain, quadrature phase
// selector, static pin decode, a behavioural oscillator with lock detection.
// Assumes all pins are synchronous to clk and that mode pins stay static.
// Behaviour
// - Disable pin high turns PLL off and divides external fast clock by 16.
// - Range pin 1 picks lower oscillator; 0 or open picks the higher one.
// - Lock output is 0 while unlocked, 1 once divided and reference clocks match.
// - Rate pin: 1 disables fast output, open gives half rate, 0 full rate.
// - Divide-by-16 is four cascaded divide-by-two stages.
// - Divide-by-8 and divide-by-16 taps feed phase detector and phase selector.
// - Phase pins low/low 0, low/high 90, high/low 180, high/high 270 degrees.
// - Buffer pin 1 or open selects LVDS 100 ohm; 0 selects CML 50 ohm.
// - The unselected oscillator is powered down completely.
// - With the div16 tap, reference at f/16 gives fast output at f or f/2, slow at f/16.
// - Oscillator is steered until divider output aligns with the reference.
module pcd_top
	import pcd_pkg::*;
#(
	parameter int PW = PCD_PERIOD_W
) (
	input  wire logic                  clk,
	input  wire logic                  clk_en,
	input  wire logic                  rst,
	input  wire logic [PCD_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	output logic                       irq,
	input  wire logic                  pll_off,
	input  wire logic                  pll_off_open,
	input  wire logic                  vco_range_sel,
	input  wire logic                  vco_range_open,
	input  wire logic                  hs_rate_ctl,
	input  wire logic                  hs_rate_open,
	input  wire logic                  phase_sel_hi,
	input  wire logic                  phase_sel_lo,
	input  wire logic                  buf_mode_ctl,
	input  wire logic                  buf_mode_open,
	input  wire logic                  hs_clk_in,
	input  wire logic                  ref_clk_in,
	output logic                       hs_clk_out,
	output logic                       hs_out_en,
	output logic                       ls_clk_out,
	output logic                       half_rate_clk,
	output logic                       div8_clk,
	output logic                       div16_clk,
	output logic                       lock,
	output logic                       pll_active,
	output logic                       vco_hi_en,
	output logic                       vco_lo_en,
	output logic                       lvds_mode
);

	// ----------------------------------------------------------------
	// Static pin decode
	// ----------------------------------------------------------------

	// An open pin reads as its default level, except the rate pin, where open selects half rate.
	wire       pll_dis   = pll_off & ~pll_off_open;
	wire       range_lo  = vco_range_sel & ~vco_range_open;
	wire       rate_dis  = ~hs_rate_open & hs_rate_ctl;
	wire       rate_full = ~hs_rate_open & ~hs_rate_ctl;
	wire       lvds_sel  = buf_mode_ctl | buf_mode_open;
	wire [1:0] phase_code = {phase_sel_hi, phase_sel_lo};

	// ----------------------------------------------------------------
	// Oscillator model and clock source
	// ----------------------------------------------------------------

	logic [PW-1:0] vco_period;
	logic [PW-1:0] vco_cnt;
	logic          full_rate;
	wire  [PW-1:0] per_min  = range_lo ? PCD_LO_MIN[PW-1:0] : PCD_HI_MIN[PW-1:0];
	wire  [PW-1:0] per_max  = range_lo ? PCD_LO_MAX[PW-1:0] : PCD_HI_MAX[PW-1:0];
	wire           vco_tick = ~pll_dis & (vco_cnt >= vco_period - PW'(1));
	wire  [PW-1:0] next_vco_cnt = (pll_dis | vco_tick) ? '0 : vco_cnt + PW'(1);
	// In bypass the fast input clock drives the divider directly.
	wire           next_full_rate = pll_dis ? hs_clk_in : (full_rate ^ vco_tick);
	wire           fr_rise  = next_full_rate & ~full_rate;

	// ----------------------------------------------------------------
	// Divide-by-16 chain
	// ----------------------------------------------------------------

	logic [PCD_STAGES-1:0] stage;
	logic [PCD_STAGES-1:0] stage_flip;
	assign stage_flip[0] = fr_rise;
	// Stage 0 flips on a full_rate rise and each later stage when the one before it falls, halving its rate.
	genvar gi;
	generate
		for (gi = 1; gi < PCD_STAGES; gi++) begin : g_chain
			assign stage_flip[gi] = stage_flip[gi-1] & stage[gi-1];
		end
	endgenerate
	wire [PCD_STAGES-1:0] next_stage = stage ^ stage_flip;
	wire div8_rise  = stage_flip[PCD_DIV8_BIT] & ~stage[PCD_DIV8_BIT];
	wire div16_rise = stage_flip[PCD_DIV16_BIT] & ~stage[PCD_DIV16_BIT];

	// Quarter index of the divide-by-16 period from the div8 and div16 taps.
	wire [1:0] quarter   = next_stage[PCD_DIV16_BIT:PCD_DIV8_BIT];
	wire [1:0] shifted_q = quarter - phase_code;

	// ----------------------------------------------------------------
	// Register file and bus decode
	// ----------------------------------------------------------------

	logic [7:0]           lock_thr;
	logic [7:0]           lag_tol;
	logic                 tap_div8;
	logic [PCD_INT_W-1:0] int_st;
	logic [PCD_INT_W-1:0] int_en;
	wire bus_wr  = avs_write & ~avs_waitrequest;
	wire sel_ctl = (avs_address == PCD_OFF_CTRL);
	wire sel_sts = (avs_address == PCD_OFF_STATUS);
	wire sel_ist = (avs_address == PCD_OFF_INT_ST);
	wire sel_ien = (avs_address == PCD_OFF_INT_EN);
	wire sel_clr = (avs_address == PCD_OFF_INT_CLR);
	wire [31:0] ctrl_word = {15'h0000, tap_div8, lag_tol, lock_thr};
	wire [31:0] stat_word = {16'h0000, vco_period[7:0], 1'b0, rate_full, rate_dis,
		lvds_mode, range_lo, pll_active, 1'b0, lock};
	wire [31:0] rd_mux = sel_ctl ? ctrl_word :
		sel_sts ? stat_word :
		sel_ist ? {30'h0, int_st} :
		sel_ien ? {30'h0, int_en} : 32'h0000_0000;

	// The PFD compares either the div16 or the div8 tap with the reference.
	logic ref_q;
	wire  ref_rise = ref_clk_in & ~ref_q;
	wire  tap_rise = tap_div8 ? div8_rise : div16_rise;

	// ----------------------------------------------------------------
	// Phase-frequency detector
	// ----------------------------------------------------------------

	pcd_pfd_t pfd_state;
	pcd_pfd_t next_pfd;
	logic [7:0] lag;
	logic [7:0] next_lag;
	logic       pfd_done;
	logic       per_up;
	logic       per_dn;

	// Measures the lag between the two edges and says which way to steer.
	always_comb begin
		next_pfd = pfd_state;
		next_lag = lag;
		pfd_done = 1'b0;
		per_up   = 1'b0;
		per_dn   = 1'b0;
		unique case (pfd_state)
			PCD_PFD_IDLE: begin
				next_lag = 8'h00;
				if (ref_rise && tap_rise) begin
					pfd_done = 1'b1;
				end else if (ref_rise) begin
					next_pfd = PCD_PFD_REF_LEAD;
				end else if (tap_rise) begin
					next_pfd = PCD_PFD_DIV_LEAD;
				end
			end
			PCD_PFD_REF_LEAD: begin
				next_lag = lag + 8'h01;
				if (tap_rise) begin
					pfd_done = 1'b1;
					per_dn   = 1'b1; // Divider is late: speed the oscillator up.
					next_pfd = PCD_PFD_IDLE;
				end else if (lag == PCD_LAG_MAX) begin
					next_pfd = PCD_PFD_IDLE;
				end
			end
			PCD_PFD_DIV_LEAD: begin
				next_lag = lag + 8'h01;
				if (ref_rise) begin
					pfd_done = 1'b1;
					per_up   = 1'b1; // Divider is early: slow the oscillator.
					next_pfd = PCD_PFD_IDLE;
				end else if (lag == PCD_LAG_MAX) begin
					next_pfd = PCD_PFD_IDLE;
				end
			end
			default: begin
				next_pfd = PCD_PFD_IDLE;
				next_lag = 8'h00;
			end
		endcase
		if (pll_dis) begin
			next_pfd = PCD_PFD_IDLE;
			next_lag = 8'h00;
		end
	end

	// A timeout or a late edge counts as a miss and breaks lock.
	wire pfd_good = pfd_done & (lag <= lag_tol);
	wire pfd_miss = ~pll_dis & ((pfd_done & ~pfd_good) |
		(pfd_state != PCD_PFD_IDLE & lag == PCD_LAG_MAX));

	// Steering moves the half period by one step, clamped to the range.
	wire [PW-1:0] next_period =
		(vco_period < per_min) ? per_min :
		(vco_period > per_max) ? per_max :
		(per_dn & ~pll_dis & vco_period > per_min) ? vco_period - PW'(1) :
		(per_up & ~pll_dis & vco_period < per_max) ? vco_period + PW'(1) : vco_period;

	logic [7:0] good_cnt;
	wire  [7:0] next_good = (pll_dis | pfd_miss) ? 8'h00 :
		(pfd_good & good_cnt < lock_thr) ? good_cnt + 8'h01 : good_cnt;
	wire        next_lock = ~pll_dis & (next_good >= lock_thr);
	wire [PCD_INT_W-1:0] int_set = {lock & ~next_lock, ~lock & next_lock};
	wire [PCD_INT_W-1:0] int_clr = (bus_wr & sel_clr) ? avs_writedata[PCD_INT_W-1:0] : '0;

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------

	// Oscillator, divider and detector state.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vco_cnt    <= '0;
			vco_period <= PCD_PERIOD_RST[PW-1:0];
			full_rate  <= 1'b0;
			stage      <= '0;
			ref_q      <= 1'b0;
			pfd_state  <= PCD_PFD_IDLE;
			lag        <= 8'h00;
			good_cnt   <= 8'h00;
		end else if (clk_en) begin
			vco_cnt    <= next_vco_cnt;
			vco_period <= next_period;
			full_rate  <= next_full_rate;
			stage      <= next_stage;
			ref_q      <= ref_clk_in;
			pfd_state  <= next_pfd;
			lag        <= next_lag;
			good_cnt   <= next_good;
		end
	end

	// Registered pin outputs.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hs_clk_out    <= 1'b0;
			hs_out_en     <= 1'b0;
			ls_clk_out    <= 1'b0;
			half_rate_clk <= 1'b0;
			div8_clk      <= 1'b0;
			div16_clk     <= 1'b0;
			lock          <= 1'b0;
			pll_active    <= 1'b0;
			vco_hi_en     <= 1'b0;
			vco_lo_en     <= 1'b0;
			lvds_mode     <= 1'b1;
		end else if (clk_en) begin
			hs_clk_out    <= ~rate_dis & (rate_full ? next_full_rate : next_stage[0]);
			hs_out_en     <= ~rate_dis;
			ls_clk_out    <= shifted_q[1];
			half_rate_clk <= next_stage[0];
			div8_clk      <= next_stage[PCD_DIV8_BIT];
			div16_clk     <= next_stage[PCD_DIV16_BIT];
			lock          <= next_lock;
			pll_active    <= ~pll_dis;
			vco_hi_en     <= ~pll_dis & ~range_lo;
			vco_lo_en     <= ~pll_dis & range_lo;
			lvds_mode     <= lvds_sel;
		end
	end

	// Bus slave: one wait cycle, then the answer, then wait again.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			lock_thr        <= PCD_THR_RST;
			lag_tol         <= PCD_TOL_RST;
			tap_div8        <= 1'b0;
			int_en          <= '0;
			int_st          <= '0;
			irq             <= 1'b0;
		end else if (clk_en) begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_mux;
			end
			if (bus_wr && sel_ctl) begin
				lock_thr <= avs_writedata[PCD_CTRL_THR_LSB +: 8];
				lag_tol  <= avs_writedata[PCD_CTRL_TOL_LSB +: 8];
				tap_div8 <= avs_writedata[PCD_CTRL_TAP8];
			end
			if (bus_wr && sel_ien) begin
				int_en <= avs_writedata[PCD_INT_W-1:0];
			end
			// A new event wins over a clear in the same cycle.
			int_st <= (int_st & ~int_clr) | int_set;
			irq    <= |(((int_st & ~int_clr) | int_set) & int_en);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_bus_req;
		clk_en && (avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_bus_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_bypass_no_lock: assert property (clk_en && pll_dis |=> !lock && !pll_active)
		else $error("Lock or active shown with PLL disabled.");
	a_one_vco_only: assert property (clk_en && !pll_dis |=> vco_hi_en != vco_lo_en)
		else $error("Both or neither oscillator enabled.");
	a_range_lower: assert property (clk_en && !pll_dis && range_lo |=> vco_lo_en)
		else $error("Lower oscillator not chosen for range pin high.");
	a_miss_drops_lock: assert property (clk_en && pfd_miss |=> !lock)
		else $error("Lock held after a phase miss.");
	a_rate_disabled: assert property (clk_en && rate_dis |=> !hs_out_en && !hs_clk_out)
		else $error("Fast output active while disabled.");
	a_chain_wrap: assert property (clk_en && fr_rise && stage == 4'hF |=> div16_clk == 1'b0
		&& div8_clk == 1'b0 && half_rate_clk == 1'b0)
		else $error("Divider chain did not wrap after sixteen edges.");
	a_phase_half: assert property (clk_en && phase_code == 2'h2 |=> ls_clk_out != div16_clk)
		else $error("180 degree phase is not the inverse of div16.");
	a_phase_zero: assert property (clk_en && phase_code == 2'h0 |=> ls_clk_out == div16_clk)
		else $error("0 degree phase differs from div16.");
	a_buf_cml: assert property (clk_en && !buf_mode_open && !buf_mode_ctl |=> !lvds_mode)
		else $error("CML mode not selected for buffer pin low.");
	a_steer_faster: assert property (clk_en && per_dn && !pll_dis && vco_period > per_min
		&& vco_period <= per_max |=> vco_period == $past(vco_period) - PW'(1))
		else $error("Oscillator not sped up when divider lags.");
	a_bus_answer: assert property (s_bus_req |=> s_bus_ans)
		else $error("Bus answer not given one cycle after request.");

endmodule

/* sim/pcd_board_model.sv */
// Board-side model: mode pins, static while driven, a fast input clock and a reference clock.
// Assumes the bench calls set_mode and drives ref_run and ref_half.
module pcd_board_model (
	input  wire logic clk,
	output logic      pll_off,
	output logic      pll_off_open,
	output logic      vco_range_sel,
	output logic      vco_range_open,
	output logic      hs_rate_ctl,
	output logic      hs_rate_open,
	output logic      phase_sel_hi,
	output logic      phase_sel_lo,
	output logic      buf_mode_ctl,
	output logic      buf_mode_open,
	output logic      hs_clk_in,
	output logic      ref_clk_in = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pin codes: 0 and 1 drive that level, 2 leaves the pin open.
	logic [1:0] off_c = 2'h2, rng_c = 2'h2, rate_c = 2'h2, bm_c = 2'h2, ph = 2'h0;
	logic [1:0] hs_cnt = 2'h0;
	logic       flip = 1'b0;
	logic       ref_run = 1'b0;
	int         ref_half = 128;
	int         ref_cnt = 0;
	// An open pin carries no level, so it shows a pattern that changes every cycle.
	assign pll_off = off_c[1] ? flip : off_c[0];
	assign pll_off_open = off_c[1];
	assign vco_range_sel = rng_c[1] ? flip : rng_c[0];
	assign vco_range_open = rng_c[1];
	assign hs_rate_ctl = rate_c[1] ? flip : rate_c[0];
	assign hs_rate_open = rate_c[1];
	assign buf_mode_ctl = bm_c[1] ? flip : bm_c[0];
	assign buf_mode_open = bm_c[1];
	assign {phase_sel_hi, phase_sel_lo} = ph;
	assign hs_clk_in = hs_cnt[1];
	// Pin codes change only here; driven pins then stay static until the next call.
	task automatic set_mode(input logic [1:0] o, r, t, b, p);
		@(posedge clk);
		off_c <= o;
		rng_c <= r;
		rate_c <= t;
		bm_c <= b;
		ph <= p;
	endtask
	// The fast clock runs at a quarter of clk; the reference stands still at 0 when stopped.
	always @(posedge clk) begin
		flip <= ~flip;
		hs_cnt <= hs_cnt + 2'h1;
		if (!ref_run) begin
			ref_clk_in <= 1'b0;
			ref_cnt <= 0;
		end else if (ref_cnt >= ref_half - 1) begin
			ref_clk_in <= ~ref_clk_in;
			ref_cnt <= 0;
		end else
			ref_cnt <= ref_cnt + 1;
	end
endmodule

/* sim/tb.sv */
// Self-checking bench: register access over Avalon-MM, pin decode, divider and lock.
// Assumes the board model drives every pin and clk_en stays high.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcd_pkg::*;
	logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, irq, hs_clk_out, hs_out_en, ls_clk_out, half_rate_clk, div8_clk;
	logic div16_clk, lock, pll_active, vco_hi_en, vco_lo_en, lvds_mode;
	wire  pll_off, pll_off_open, vco_range_sel, vco_range_open, hs_rate_ctl, hs_rate_open;
	wire  phase_sel_hi, phase_sel_lo, buf_mode_ctl, buf_mode_open, hs_clk_in, ref_clk_in;
	int   errors = 0, n_checks = 0, cyc = 0, cnt [5];

	pcd_top DUT (.clk, .clk_en(1'b1), .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .pll_off, .pll_off_open,
		.vco_range_sel, .vco_range_open, .hs_rate_ctl, .hs_rate_open, .phase_sel_hi,
		.phase_sel_lo, .buf_mode_ctl, .buf_mode_open, .hs_clk_in, .ref_clk_in, .hs_clk_out,
		.hs_out_en, .ls_clk_out, .half_rate_clk, .div8_clk, .div16_clk, .lock, .pll_active,
		.vco_hi_en, .vco_lo_en, .lvds_mode);
	pcd_board_model board (.clk, .pll_off, .pll_off_open, .vco_range_sel, .vco_range_open,
		.hs_rate_ctl, .hs_rate_open, .phase_sel_hi, .phase_sel_lo, .buf_mode_ctl,
		.buf_mode_open, .hs_clk_in, .ref_clk_in);

	// ------------------------------------------------------------
	// Clock, timeout and closing report
	// ------------------------------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end
	// A hang anywhere ends the run after a ceiling well above the expected length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus access and comparisons
	// ------------------------------------------------------------
	// One Avalon-MM access; the request holds until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, hi, g);
		n_checks++;
		if (g < lo || g > hi) begin
			errors++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Counts rising edges of the fast, half, div8, div16 and slow outputs.
	task automatic count(input int n);
		logic [4:0] p, c;
		cnt = '{default: 0};
		p = {hs_clk_out, half_rate_clk, div8_clk, div16_clk, ls_clk_out};
		repeat (n) begin
			@(posedge clk);
			c = {hs_clk_out, half_rate_clk, div8_clk, div16_clk, ls_clk_out};
			for (int k = 0; k < 5; k++)
				if (c[k] && !p[k])
					cnt[k]++;
			p = c;
		end
	endtask
	// Cycles from a div16 rise to the next rise of the slow output.
	task automatic phase(input int c, output int d);
		logic pd, pl;
		board.set_mode(2'h1, 2'h2, 2'h2, 2'h2, 2'(c));
		repeat (200) @(posedge clk);
		pd = 1'b1;
		pl = 1'b1;
		d = -1;
		repeat (300) begin
			@(posedge clk);
			if (d < 0 && div16_clk === 1'b1 && !pd)
				d = 0;
			if (d >= 0 && ls_clk_out === 1'b1 && !pl)
				break;
			if (d >= 0)
				d++;
			pd = div16_clk;
			pl = ls_clk_out;
		end
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		int o, r, t, b, d, n;
		logic on;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Reset values, read-back, unmapped and write-only places.
		bus(0, PCD_OFF_CTRL, 0);
		chk("ctrl reset", {16'h0000, PCD_TOL_RST, PCD_THR_RST}, rd);
		bus(1, PCD_OFF_CTRL, 32'h0001_0A05);
		bus(0, PCD_OFF_CTRL, 0);
		chk("ctrl write", 32'h0001_0A05, rd);
		bus(1, PCD_OFF_CTRL, {16'h0000, PCD_TOL_RST, PCD_THR_RST});
		bus(1, 8'h20, 32'hFFFF_FFFF);
		bus(0, 8'h20, 0);
		chk("unmapped", 32'h0, rd);
		bus(0, PCD_OFF_INT_CLR, 0);
		chk("int clear reg", 32'h0, rd);
		bus(0, PCD_OFF_INT_EN, 0);
		chk("int enable reset", 32'h0, rd);
		$display("test registers done");
		// Every code of each mode pin except the phase pins, rotated across the pins.
		for (int i = 0; i < 3; i++) begin
			o = i;
			r = (i + 1) % 3;
			t = (i + 2) % 3;
			b = i;
			on = (o != 1);
			board.set_mode(2'(o), 2'(r), 2'(t), 2'(b), 2'h0);
			repeat (4) @(posedge clk);
			chk("pins", {on, on && r != 1, on && r == 1, t != 1, b != 0},
				{pll_active, vco_hi_en, vco_lo_en, hs_out_en, lvds_mode});
			bus(0, PCD_OFF_STATUS, 0);
			chk("status", {t == 0, t == 1, b != 0, r == 1, on}, rd[6:2]);
		end
		$display("test decode done");
		// Bypass: the fast input has a period of 4 cycles, so div16 has 64.
		for (int k = 0; k < 3; k++) begin
			board.set_mode(2'h1, 2'h2, 2'(k), 2'h2, 2'h0);
			repeat (100) @(posedge clk);
			count(1024);
			n = (k == 0) ? 256 : (k == 2) ? 128 : 0;
			chk_rng("fast out", n - 1, n + 1, cnt[4]);
			chk_rng("half", 127, 129, cnt[3]);
			chk_rng("div8", 31, 33, cnt[2]);
			chk_rng("div16", 15, 17, cnt[1]);
			chk_rng("slow out", 15, 17, cnt[0]);
		end
		for (int c = 0; c < 4; c++) begin
			phase(c, d);
			chk_rng("phase delay", c * 16, c * 16 + 3, d);
		end
		$display("test divider done");
		// Lock on a reference of 256 cycles, then lose it by stopping the reference.
		// A reset restores the nominal half period left behind by the range tests.
		board.set_mode(2'h0, 2'h2, 2'h2, 2'h2, 2'h0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("reset out", 32'h2, {lock, avs_waitrequest, irq});
		bus(1, PCD_OFF_INT_EN, 32'h3);
		board.ref_half <= 128;
		// The first div16 rise is taken and the second times out, so the reference
		// is started to meet the third rise in the same cycle.
		@(posedge div16_clk);
		repeat (383) @(posedge clk);
		board.ref_run <= 1'b1;
		n = 0;
		while (lock !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		chk("lock", 1, lock);
		chk("irq gained", 1, irq);
		bus(0, PCD_OFF_STATUS, 0);
		chk("status lock", 1, rd[0]);
		count(2048);
		chk_rng("div16 locked", 7, 9, cnt[1]);
		chk_rng("half rate out", 56, 72, cnt[4]);
		chk_rng("slow locked", 7, 9, cnt[0]);
		bus(1, PCD_OFF_INT_CLR, 32'h3);
		bus(0, PCD_OFF_INT_ST, 0);
		chk("int cleared", 32'h0, rd);
		bus(1, PCD_OFF_INT_EN, 32'h2);
		board.ref_run <= 1'b0;
		n = 0;
		while (lock !== 1'b0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		chk("unlock", 0, lock);
		chk("irq lost", 1, irq);
		bus(0, PCD_OFF_INT_ST, 0);
		chk("int lost", 32'h2, rd);
		bus(1, PCD_OFF_INT_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq masked", 0, irq);
		$display("test lock done");
		complete_run();
	end
endmodule
